/* include/trr_pkg.sv */
/*
 * shared constants for the temperature reading register bank:
 * register offsets, field positions, reset values and reading formats.
 * assumes a byte-wide register port driven by a serial management front end.
 */
package trr_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] OFS_REMOTE_SIGNED_UPPER = 8'h01;
    localparam logic [7:0] OFS_LOCAL_HIGH_LIMIT = 8'h05;
    localparam logic [7:0] OFS_REMOTE_SIGNED_LOWER = 8'h10;
    localparam logic [7:0] OFS_REMOTE_UNSIGNED_UPPER = 8'h31;
    localparam logic [7:0] OFS_REMOTE_UNSIGNED_LOWER = 8'h32;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] LOCAL_HIGH_LIMIT_RST = 8'h46;
    localparam logic [7:0] READING_RST = 8'h00;

    // ----------------------------------------------------------------
    // reading format: 13-bit remote value, 8 integer and 5 fraction bits
    // ----------------------------------------------------------------
    localparam int REMOTE_W = 13;
    localparam int FRAC_W = 5;
    localparam int EXT_W = 2;
    localparam int LOWER_POS = 3;
    // signed reading above 127.875: non-negative and above 0x7F.111 00
    localparam logic [12:0] SIGNED_EXT_LIMIT = 13'h0FFC;
    localparam logic [1:0] EXT_SATURATED = 2'h3;

endpackage

/* rtl/trr_lower_format.sv */
/*
 * builds one remote lower byte from the five fraction bits of a reading.
 * assumes the reading and mode inputs are on the same clock as the caller.
 */
`timescale 1ns/10ps
module trr_lower_format (
    input wire logic [4:0] frac_in,
    input wire logic filter_on_in,
    input wire logic ext_res_in,
    input wire logic signed_fmt_in,
    input wire logic over_limit_in,
    output logic [7:0] byte_out
);

    // choose the two extended bits by filter, resolution and format
    logic [1:0] ext_bits;
    always_comb begin
        ext_bits = 2'h0;
        if (signed_fmt_in) begin
            if (filter_on_in && ext_res_in) begin
                ext_bits = frac_in[1:0];
            end else if (!filter_on_in && ext_res_in && over_limit_in) begin
                ext_bits = trr_pkg::EXT_SATURATED;
            end
        end else if (filter_on_in) begin
            ext_bits = frac_in[1:0];
        end
    end

    // fractions in 7:5, extended bits in 4:3, unused bits read zero
    assign byte_out = {frac_in[4:2], ext_bits, 3'h0};

endmodule

/* rtl/trr_temp_regs.sv */
/*
 * temperature reading register bank: local reading, local high limit,
 * signed and unsigned remote readings split into upper and lower bytes.
 * register map, byte offsets:
 *   0x00 local reading, read only
 *   0x01 signed remote upper byte, read only, captures its lower byte
 *   0x05 local high limit, read and write
 *   0x10 signed remote lower byte, read only, value held by 0x01
 *   0x31 unsigned remote upper byte, read only, captures its lower byte
 *   0x32 unsigned remote lower byte, read only, value held by 0x31
 *   other offsets read zero and ignore writes
 * assumes a byte-wide register port from a serial management front end,
 * with one-cycle read and write strobes and the answer a cycle later,
 * and readings supplied by a measurement engine on the same clock.
 */
// How it works
// - local reading shown as 8-bit signed integer degrees
// - local high limit read/write, signed degrees, resets to 0x46
// - signed upper byte holds top eight bits of signed remote reading
// - signed lower byte bits 7:5 weigh half, quarter, eighth degree
// - filter off: low reading bits 00, or 11 above 127.875 if extended
// - lower byte bits 2:0 always read zero
// - unsigned upper byte holds top eight bits, bit 7 weighs 128
// - unsigned lower fractions; low bits 00 unfiltered, fine when filtered
`timescale 1ns/10ps
module trr_temp_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] local_temp_in,
    input wire logic [12:0] remote_signed_in,
    input wire logic [12:0] remote_unsigned_in,
    input wire logic filter_on_in,
    input wire logic extended_resolution_enable_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic [7:0] local_high_limit_out
);

    // ----------------------------------------------------------------
    // register select
    // ----------------------------------------------------------------
    // one code per mapped register, plus none for every unmapped offset
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_LOCAL_TEMP,
        SEL_LOCAL_HIGH_LIMIT,
        SEL_SIGNED_UPPER,
        SEL_SIGNED_LOWER,
        SEL_UNSIGNED_UPPER,
        SEL_UNSIGNED_LOWER
    } trr_sel_t;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // map an offset to its register; shared by the write and read paths
    function automatic trr_sel_t decode_sel(input logic [7:0] addr);
        trr_sel_t sel;
        unique case (addr)
            trr_pkg::OFS_LOCAL_TEMP: begin
                sel = SEL_LOCAL_TEMP;
            end
            trr_pkg::OFS_LOCAL_HIGH_LIMIT: begin
                sel = SEL_LOCAL_HIGH_LIMIT;
            end
            trr_pkg::OFS_REMOTE_SIGNED_UPPER: begin
                sel = SEL_SIGNED_UPPER;
            end
            trr_pkg::OFS_REMOTE_SIGNED_LOWER: begin
                sel = SEL_SIGNED_LOWER;
            end
            trr_pkg::OFS_REMOTE_UNSIGNED_UPPER: begin
                sel = SEL_UNSIGNED_UPPER;
            end
            trr_pkg::OFS_REMOTE_UNSIGNED_LOWER: begin
                sel = SEL_UNSIGNED_LOWER;
            end
            default: begin
                sel = SEL_NONE; // unmapped offsets
            end
        endcase
        return sel;
    endfunction

    // integer byte of a reading: its top eight bits, in both formats
    function automatic logic [7:0] upper_byte(input logic [12:0] reading);
        return reading[12:5];
    endfunction

    // signed reading past the top of its range: non-negative, above 127.875
    function automatic logic signed_beyond(input logic [12:0] reading);
        return !reading[12] && (reading > trr_pkg::SIGNED_EXT_LIMIT);
    endfunction

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the slices below assume eight integer bits over five fraction bits
    if (trr_pkg::REMOTE_W != 8 + trr_pkg::FRAC_W) begin : g_bad_remote_w
        $error("remote reading must be eight integer bits plus fraction");
    end
    // the extended pair sits just below the three coarse fraction bits
    if (trr_pkg::FRAC_W != 3 + trr_pkg::EXT_W) begin : g_bad_frac_w
        $error("fraction must be three coarse bits plus the extended pair");
    end
    // the three unused bits of each lower byte sit under the fraction
    if (trr_pkg::LOWER_POS != 8 - trr_pkg::FRAC_W) begin : g_bad_lower_pos
        $error("lower byte fraction must start above three unused bits");
    end

    // ----------------------------------------------------------------
    // decode and live lower bytes
    // ----------------------------------------------------------------
    trr_sel_t addr_sel;
    logic wr_limit;
    logic rd_signed_upper;
    logic rd_unsigned_upper;
    logic signed_over;
    logic [7:0] signed_lower_live;
    logic [7:0] unsigned_lower_live;

    // one decode serves both strobes; a read and a write may share a cycle
    assign addr_sel = decode_sel(addr_in);
    assign wr_limit = wr_en_in && (addr_sel == SEL_LOCAL_HIGH_LIMIT);
    assign rd_signed_upper = rd_en_in && (addr_sel == SEL_SIGNED_UPPER);
    assign rd_unsigned_upper = rd_en_in && (addr_sel == SEL_UNSIGNED_UPPER);

    // saturation flag feeds the extended bits of the signed lower byte
    assign signed_over = signed_beyond(remote_signed_in);

    // live lower byte of the signed reading
    trr_lower_format u_signed_lower (
        .frac_in(remote_signed_in[4:0]),
        .filter_on_in(filter_on_in),
        .ext_res_in(extended_resolution_enable_in),
        .signed_fmt_in(1'b1),
        .over_limit_in(signed_over),
        .byte_out(signed_lower_live)
    );

    // live lower byte of the unsigned reading
    trr_lower_format u_unsigned_lower (
        .frac_in(remote_unsigned_in[4:0]),
        .filter_on_in(filter_on_in),
        .ext_res_in(extended_resolution_enable_in),
        .signed_fmt_in(1'b0),
        .over_limit_in(1'b0),
        .byte_out(unsigned_lower_live)
    );

    // ----------------------------------------------------------------
    // local high limit
    // ----------------------------------------------------------------
    logic [7:0] local_high_limit_r;
    logic [7:0] local_high_limit_nxt;

    // only a write to the limit offset changes it; others are ignored
    always_comb begin
        local_high_limit_nxt = local_high_limit_r;
        if (wr_limit) begin
            local_high_limit_nxt = wr_data_in;
        end
    end

    // limit register, back at its power-on value after reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            local_high_limit_r <= trr_pkg::LOCAL_HIGH_LIMIT_RST;
        end else begin
            local_high_limit_r <= local_high_limit_nxt;
        end
    end

    // ----------------------------------------------------------------
    // signed lower byte capture
    // ----------------------------------------------------------------
    logic [7:0] signed_lower_r;
    logic [7:0] signed_lower_nxt;

    // an upper read freezes its lower byte, so a later lower read
    // belongs to the same sample even if the reading moved meanwhile
    always_comb begin
        signed_lower_nxt = signed_lower_r;
        if (rd_signed_upper) begin
            signed_lower_nxt = signed_lower_live;
        end
    end

    // captured byte reads zero until the first upper read after reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            signed_lower_r <= trr_pkg::READING_RST;
        end else begin
            signed_lower_r <= signed_lower_nxt;
        end
    end

    // ----------------------------------------------------------------
    // unsigned lower byte capture
    // ----------------------------------------------------------------
    logic [7:0] unsigned_lower_r;
    logic [7:0] unsigned_lower_nxt;

    // same freeze for the unsigned pair, keyed on its own upper offset
    always_comb begin
        unsigned_lower_nxt = unsigned_lower_r;
        if (rd_unsigned_upper) begin
            unsigned_lower_nxt = unsigned_lower_live;
        end
    end

    // captured byte reads zero until the first upper read after reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unsigned_lower_r <= trr_pkg::READING_RST;
        end else begin
            unsigned_lower_r <= unsigned_lower_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;

    // read mux; the data holds between reads for a slow front end
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_en_in) begin
            unique case (addr_sel)
                SEL_NONE: begin
                    rd_data_nxt = 8'h00; // unmapped reads zero
                end
                SEL_LOCAL_TEMP: begin
                    rd_data_nxt = local_temp_in;
                end
                SEL_LOCAL_HIGH_LIMIT: begin
                    rd_data_nxt = local_high_limit_r;
                end
                SEL_SIGNED_UPPER: begin
                    rd_data_nxt = upper_byte(remote_signed_in);
                end
                SEL_SIGNED_LOWER: begin
                    rd_data_nxt = signed_lower_r;
                end
                SEL_UNSIGNED_UPPER: begin
                    rd_data_nxt = upper_byte(remote_unsigned_in);
                end
                SEL_UNSIGNED_LOWER: begin
                    rd_data_nxt = unsigned_lower_r;
                end
                default: begin
                    rd_data_nxt = 8'h00; // eighth code is never decoded
                end
            endcase
        end
    end

    // read data register, zero out of reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_r <= trr_pkg::READING_RST;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read answer
    // ----------------------------------------------------------------
    logic rd_valid_r;
    logic rd_valid_nxt;

    // every read is answered exactly one cycle later, mapped or not
    always_comb begin
        rd_valid_nxt = rd_en_in;
    end

    // one-cycle answer pulse, low out of reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // every output comes straight from its register
    assign rd_data_out = rd_data_r;
    assign rd_valid_out = rd_valid_r;
    assign local_high_limit_out = local_high_limit_r;

endmodule

/* sim/trr_temp_regs_props.sv */
/* checker for the temperature register bank
   sees only the bank ports; bound after the module */
`timescale 1ns/10ps
module trr_temp_regs_props (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] local_temp_in,
    input wire logic [12:0] remote_signed_in,
    input wire logic [7:0] rd_data_out,
    input wire logic rd_valid_out,
    input wire logic [7:0] local_high_limit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // -------------------------
    // request decode and capture
    // -------------------------
    wire su = rd_en_in && addr_in == 8'h01;
    wire sl = rd_en_in && addr_in == 8'h10;
    wire lw = wr_en_in && addr_in == 8'h05;
    logic [2:0] cap_r;
    // fraction seen at the last signed upper read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) cap_r <= 3'h0;
        else if (su) cap_r <= remote_signed_in[4:2];
    end
    local_rd_a: assert property (rd_en_in && addr_in == 8'h00 |=>
        rd_data_out == $past(local_temp_in)) else $error("local read");
    lim_wr_a: assert property (lw |=> local_high_limit_out == $past(wr_data_in))
        else $error("limit write");
    lim_hold_a: assert property (!lw |=> $stable(local_high_limit_out))
        else $error("limit changed");
    sgn_up_a: assert property (su |=> rd_data_out == $past(remote_signed_in[12:5]))
        else $error("signed upper");
    sgn_frac_a: assert property (sl |=> rd_data_out[7:5] == $past(cap_r))
        else $error("signed lower");
    low_zero_a: assert property (rd_en_in && addr_in inside {8'h10, 8'h32} |=>
        rd_data_out[2:0] == 3'h0) else $error("lower low bits");
    rd_ans_a: assert property (rd_en_in |=> rd_valid_out) else $error("no answer");
    rd_one_a: assert property (rd_valid_out |-> $past(rd_en_in)) else $error("extra answer");
    cover property (su ##[1:8] sl);
    cover property (lw);
    cover property (rd_en_in && addr_in == 8'h32);
endmodule
bind trr_temp_regs trr_temp_regs_props trr_temp_regs_props_inst (.*);

/* sim/trr_host.sv */
/* host model: master of the byte register port
   assumes calls start just after a rising clock edge */
`timescale 1ns/10ps
module trr_host (
    input wire logic clk_in,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_data_in,
    output logic [7:0] addr_out,
    output logic rd_en_out,
    output logic wr_en_out,
    output logic [7:0] wr_data_out
);
    // idle request lines
    initial begin
        {addr_out, rd_en_out, wr_en_out, wr_data_out} = 18'h0;
    end
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_out <= a;
        wr_data_out <= d;
        wr_en_out <= 1'b1;
        @(posedge clk_in);
        wr_en_out <= 1'b0;
    endtask
    // one-cycle read strobe, bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        addr_out <= a;
        rd_en_out <= 1'b1;
        @(posedge clk_in);
        rd_en_out <= 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 8 && !ok; n++) begin
            @(negedge clk_in);
            ok = (rd_valid_in === 1'b1);
        end
        d = rd_data_in;
        @(posedge clk_in);
    endtask
endmodule

/* sim/tb.sv */
/* self-checking bench for the temperature register bank
   assumes trr_host drives the register port */
`timescale 1ns/10ps
module tb;
    logic clk_in, rst_n_in, wr_en_in, rd_en_in, rd_valid_out, filter_on_in;
    logic extended_resolution_enable_in;
    logic [7:0] addr_in, wr_data_in, local_temp_in, rd_data_out, local_high_limit_out;
    logic [12:0] remote_signed_in, remote_unsigned_in;
    int n_errors = 0;
    int tests_run = 0;
    // clock of 5 ns period
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    trr_temp_regs trr_temp_regs_inst (.*);
    trr_host trr_host_inst (.clk_in(clk_in), .rd_valid_in(rd_valid_out),
        .rd_data_in(rd_data_out), .addr_out(addr_in), .rd_en_out(rd_en_in),
        .wr_en_out(wr_en_in), .wr_data_out(wr_data_in));
    // -------------------------
    // compare, read and verdict
    // -------------------------
    task automatic finish_test();
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        trr_host_inst.rd(a, d, ok);
        // a missing answer counts once; the run still reaches the verdict
        if (!ok) begin
            n_errors++;
        end
        chk(d, exp);
    endtask
    // upper then lower, reading changed in between
    task automatic pair(input logic f, e, input logic [7:0] a, input logic [12:0] v,
        input logic [7:0] eu, el);
        filter_on_in <= f;
        extended_resolution_enable_in <= e;
        if (a == 8'h01) remote_signed_in <= v;
        else remote_unsigned_in <= v;
        @(posedge clk_in);
        rdc(a, eu);
        remote_signed_in <= ~v;
        remote_unsigned_in <= ~v;
        rdc((a == 8'h01) ? 8'h10 : 8'h32, el);
    endtask
    // main sequence
    initial begin
        rst_n_in <= 1'b0;
        {local_temp_in, remote_signed_in, remote_unsigned_in} <= 34'h0;
        {filter_on_in, extended_resolution_enable_in} <= 2'h0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        chk(local_high_limit_out, 8'h46);
        rdc(8'h05, 8'h46);
        trr_host_inst.wr(8'h05, 8'hE7);
        rdc(8'h05, 8'hE7);
        trr_host_inst.wr(8'h00, 8'h11);
        rdc(8'h05, 8'hE7);
        chk(local_high_limit_out, 8'hE7);
        local_temp_in <= 8'h9C;
        rdc(8'h00, 8'h9C);
        rdc(8'h07, 8'h00);
        rdc(8'h10, 8'h00);
        rdc(8'h32, 8'h00);
        pair(1'b0, 1'b0, 8'h01, 13'h0FFF, 8'h7F, 8'hE0);
        pair(1'b0, 1'b1, 8'h01, 13'h0FFF, 8'h7F, 8'hF8);
        pair(1'b0, 1'b1, 8'h01, 13'h1A6B, 8'hD3, 8'h40);
        pair(1'b1, 1'b1, 8'h01, 13'h1A6B, 8'hD3, 8'h58);
        pair(1'b1, 1'b0, 8'h01, 13'h0FFF, 8'h7F, 8'hE0);
        pair(1'b0, 1'b1, 8'h31, 13'h1E4F, 8'hF2, 8'h60);
        pair(1'b1, 1'b0, 8'h31, 13'h1E4F, 8'hF2, 8'h78);
        finish_test();
    end
endmodule
